// [hw/ucrm_pkg.sv]
`default_nettype none
// shared constants for the uart channel register map
package ucrm_pkg;

  // bus widths of the parallel host port and the modem pins
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int MODEM_W = 4;
  localparam int STB_W = 3;

  // address offsets, shared by the overlaid register sets
  localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_IER = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_ISR = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_LCR = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_MCR = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_LSR = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_MSR = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_SCR = 3'h7;

  // line control value that opens the enhanced set
  localparam logic [DATA_W-1:0] ENH_KEY = 8'hBF;

  // field positions
  localparam int LCR_DIV_BIT = 7;
  localparam int EFR_ENH_BIT = 4;
  localparam int FCR_EN_BIT = 0;

  // bits that only exist while enhanced functions are on
  localparam logic [DATA_W-1:0] IER_ENH_MASK = 8'hF0;
  localparam logic [DATA_W-1:0] ISR_ENH_MASK = 8'h30;
  localparam logic [DATA_W-1:0] FCR_ENH_MASK = 8'h30;
  localparam logic [DATA_W-1:0] MCR_ENH_MASK = 8'hE0;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;

  // reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [MODEM_W-1:0] MODEM_IDLE = 4'hF;
  localparam logic [MODEM_W-1:0] DELTA_NONE = 4'h0;
  localparam logic [STB_W-1:0] STROBE_IDLE = 3'h7;

  // positions of the synchronised strobes
  localparam int STB_CS = 2;
  localparam int STB_RD = 1;
  localparam int STB_WR = 0;

  // register selected by one access
  typedef enum logic [4:0] {
    SEL_NONE = 5'h00,
    SEL_DATA = 5'h01,
    SEL_IER = 5'h02,
    SEL_ISR_FCR = 5'h03,
    SEL_LCR = 5'h04,
    SEL_MCR = 5'h05,
    SEL_LSR = 5'h06,
    SEL_MSR = 5'h07,
    SEL_SCR = 5'h08,
    SEL_DLL = 5'h09,
    SEL_DLM = 5'h0A,
    SEL_DLD = 5'h0B,
    SEL_EFR = 5'h0C,
    SEL_RESUME_CHAR_ONE = 5'h0D,
    SEL_RESUME_CHAR_TWO = 5'h0E,
    SEL_PAUSE_CHAR_ONE = 5'h0F,
    SEL_PAUSE_CHAR_TWO = 5'h10
  } ucrm_sel_t;

endpackage
`default_nettype wire

// [hw/ucrm_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// three-stage pin synchroniser with an agreement filter
module ucrm_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  // refuse a zero-width instance
  if (WIDTH < 1) begin : g_bad_width
    $error("ucrm_pin_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] stage1; // metastable catch, read by stage2 only
  logic [WIDTH-1:0] stage2; // first settled copy
  logic [WIDTH-1:0] stage3; // second settled copy
  logic [WIDTH-1:0] next_level; // filtered level
  logic [WIDTH-1:0] differ; // stages disagree

  // a bit moves only once stage2 and stage3 agree
  always_comb begin
    differ = stage2 ^ stage3;
    next_level = (~differ & stage3) | (differ & o_level);
  end

  // shift chain and filtered level
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      o_level <= RESET_VAL;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      o_level <= next_level;
    end
  end

endmodule // ucrm_pin_sync
`default_nettype wire

// [hw/ucrm_channel_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module ucrm_channel_regs (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // parallel host port, all asynchronous pins
  input wire logic i_cs_b,
  input wire logic i_rd_b,
  input wire logic i_wr_b,
  input wire logic [ucrm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ucrm_pkg::DATA_W-1:0] i_data,
  output logic [ucrm_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  // modem input pins, active low
  input wire logic i_cts_b,
  input wire logic i_dsr_b,
  input wire logic i_ri_b,
  input wire logic i_cd_b,
  // status from the channel core, same clock
  input wire logic [ucrm_pkg::DATA_W-1:0] i_rx_byte,
  input wire logic [ucrm_pkg::DATA_W-1:0] i_line_status,
  input wire logic [3:0] i_int_source,
  input wire logic i_xoff_int,
  input wire logic i_rtscts_int,
  // access events toward the channel core
  output logic o_rx_read,
  output logic o_tx_load,
  output logic [ucrm_pkg::DATA_W-1:0] o_tx_byte,
  output logic o_isr_read,
  output logic o_lsr_read,
  output logic o_fifo_write,
  // configuration registers
  output logic [ucrm_pkg::DATA_W-1:0] o_int_enable,
  output logic [ucrm_pkg::DATA_W-1:0] o_fifo_control,
  output logic [ucrm_pkg::DATA_W-1:0] o_line_control,
  output logic [ucrm_pkg::DATA_W-1:0] o_modem_control,
  output logic [ucrm_pkg::DATA_W-1:0] o_divisor_low,
  output logic [ucrm_pkg::DATA_W-1:0] o_divisor_high,
  output logic [ucrm_pkg::DATA_W-1:0] o_divisor_fraction,
  output logic [ucrm_pkg::DATA_W-1:0] o_enhanced_feature,
  output logic [ucrm_pkg::DATA_W-1:0] o_resume_char_one,
  output logic [ucrm_pkg::DATA_W-1:0] o_resume_char_two,
  output logic [ucrm_pkg::DATA_W-1:0] o_pause_char_one,
  output logic [ucrm_pkg::DATA_W-1:0] o_pause_char_two
);
  import ucrm_pkg::*;

  // decode one access from address and current line control
  function automatic ucrm_sel_t reg_decode(
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] line_control,
    input logic enh
  );
    ucrm_sel_t sel;
    sel = SEL_NONE;
    if (line_control == ENH_KEY) begin
      unique case (addr)
        ADDR_ISR: sel = SEL_EFR;
        ADDR_LCR: sel = SEL_LCR;
        ADDR_MCR: sel = SEL_RESUME_CHAR_ONE;
        ADDR_LSR: sel = SEL_RESUME_CHAR_TWO;
        ADDR_MSR: sel = SEL_PAUSE_CHAR_ONE;
        ADDR_SCR: sel = SEL_PAUSE_CHAR_TWO;
        // divisor bytes are hidden behind the key
        default: sel = SEL_NONE;
      endcase
    end else begin
      unique case (addr)
        ADDR_DATA: sel = line_control[LCR_DIV_BIT] ? SEL_DLL : SEL_DATA;
        ADDR_IER: sel = line_control[LCR_DIV_BIT] ? SEL_DLM : SEL_IER;
        ADDR_ISR: begin
          if (line_control[LCR_DIV_BIT]) begin
            sel = enh ? SEL_DLD : SEL_NONE;
          end else begin
            sel = SEL_ISR_FCR;
          end
        end
        ADDR_LCR: sel = SEL_LCR;
        ADDR_MCR: sel = SEL_MCR;
        ADDR_LSR: sel = SEL_LSR;
        ADDR_MSR: sel = SEL_MSR;
        ADDR_SCR: sel = SEL_SCR;
      endcase
    end
    return sel;
  endfunction

  // mask that keeps gated bits out unless enhanced is on
  function automatic logic [DATA_W-1:0] enh_keep(
    input logic [DATA_W-1:0] gated,
    input logic enh
  );
    return enh ? ALL_ONES : ~gated;
  endfunction

  logic [STB_W-1:0] strobe_b_lvl; // filtered {cs, rd, wr}
  logic [ADDR_W-1:0] addr_lvl; // filtered address
  logic [DATA_W-1:0] wdata_lvl; // filtered write data
  logic [MODEM_W-1:0] modem_b_lvl; // filtered {cd, ri, dsr, cts}
  logic rd_active; // read cycle in progress
  logic wr_active; // write cycle in progress
  logic rd_prev; // last cycle's read level
  logic wr_prev; // last cycle's write level
  logic rd_start; // read strobe just asserted
  logic wr_done; // write strobe just released
  logic enh_on; // enhanced functions enabled
  ucrm_sel_t sel; // register hit by current address
  logic [DATA_W-1:0] rd_value; // read mux result

  // strobes, address and data all come off pins
  ucrm_pin_sync #(
    .WIDTH(STB_W),
    .RESET_VAL(STROBE_IDLE)
  ) u_strobe_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_cs_b, i_rd_b, i_wr_b}),
    .o_level(strobe_b_lvl)
  );

  // address and data share one chain so their delay matches the strobes
  ucrm_pin_sync #(
    .WIDTH(ADDR_W + DATA_W),
    .RESET_VAL('0)
  ) u_bus_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_addr, i_data}),
    .o_level({addr_lvl, wdata_lvl})
  );

  // modem inputs idle high, so reset to idle to avoid false deltas
  ucrm_pin_sync #(
    .WIDTH(MODEM_W),
    .RESET_VAL(MODEM_IDLE)
  ) u_modem_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_cd_b, i_ri_b, i_dsr_b, i_cts_b}),
    .o_level(modem_b_lvl)
  );

  // registers held only here
  logic [DATA_W-1:0] scratch; // free host byte
  logic [MODEM_W-1:0] modem_prev; // modem level one cycle back
  logic [MODEM_W-1:0] modem_delta; // sticky change flags

  // access detection and read mux
  always_comb begin
    rd_active = ~strobe_b_lvl[STB_CS] & ~strobe_b_lvl[STB_RD];
    wr_active = ~strobe_b_lvl[STB_CS] & ~strobe_b_lvl[STB_WR];
    // reads act at the start, writes at the end when data is settled
    rd_start = rd_active & ~rd_prev;
    wr_done = ~wr_active & wr_prev;
    enh_on = o_enhanced_feature[EFR_ENH_BIT];
    sel = reg_decode(addr_lvl, o_line_control, enh_on);
    rd_value = RST_BYTE;
    unique case (sel)
      SEL_DATA: rd_value = i_rx_byte;
      // stored enables, gated bits already clear
      SEL_IER: rd_value = o_int_enable;
      // status with fifo flags and gated bits
      SEL_ISR_FCR: rd_value = {{2{o_fifo_control[FCR_EN_BIT]}}, i_rtscts_int,
        i_xoff_int, i_int_source} & enh_keep(ISR_ENH_MASK, enh_on);
      SEL_LCR: rd_value = o_line_control;
      SEL_MCR: rd_value = o_modem_control;
      SEL_LSR: rd_value = i_line_status;
      // input states are shown active high
      SEL_MSR: rd_value = {~modem_b_lvl, modem_delta};
      SEL_SCR: rd_value = scratch;
      SEL_DLL: rd_value = o_divisor_low;
      SEL_DLM: rd_value = o_divisor_high;
      SEL_DLD: rd_value = o_divisor_fraction;
      SEL_EFR: rd_value = o_enhanced_feature;
      SEL_RESUME_CHAR_ONE: rd_value = o_resume_char_one;
      SEL_RESUME_CHAR_TWO: rd_value = o_resume_char_two;
      SEL_PAUSE_CHAR_ONE: rd_value = o_pause_char_one;
      SEL_PAUSE_CHAR_TWO: rd_value = o_pause_char_two;
      // unmapped overlay slots read zero
      SEL_NONE: rd_value = RST_BYTE;
    endcase
  end

  // next values of the bus side: data, enable and event pulses
  logic next_rd_prev;
  logic next_wr_prev;
  logic [DATA_W-1:0] next_data;
  logic next_data_oe;
  logic next_rx_read;
  logic next_tx_load;
  logic [DATA_W-1:0] next_tx_byte;
  logic next_isr_read;
  logic next_lsr_read;
  logic next_fifo_write;

  // read data is caught once per read and held for the whole strobe
  always_comb begin
    next_rd_prev = rd_active;
    next_wr_prev = wr_active;
    next_data = rd_start ? rd_value : o_data;
    next_data_oe = rd_active;
    next_rx_read = rd_start & (sel == SEL_DATA);
    next_isr_read = rd_start & (sel == SEL_ISR_FCR);
    next_lsr_read = rd_start & (sel == SEL_LSR);
    next_tx_load = wr_done & (sel == SEL_DATA);
    next_tx_byte = next_tx_load ? wdata_lvl : o_tx_byte;
    next_fifo_write = wr_done & (sel == SEL_ISR_FCR);
  end

  // bus side flops
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      o_data <= RST_BYTE;
      o_data_oe <= 1'b0;
      o_rx_read <= 1'b0;
      o_tx_load <= 1'b0;
      o_tx_byte <= RST_BYTE;
      o_isr_read <= 1'b0;
      o_lsr_read <= 1'b0;
      o_fifo_write <= 1'b0;
    end else begin
      rd_prev <= next_rd_prev;
      wr_prev <= next_wr_prev;
      o_data <= next_data;
      o_data_oe <= next_data_oe;
      o_rx_read <= next_rx_read;
      o_tx_load <= next_tx_load;
      o_tx_byte <= next_tx_byte;
      o_isr_read <= next_isr_read;
      o_lsr_read <= next_lsr_read;
      o_fifo_write <= next_fifo_write;
    end
  end

  // next values of the register file
  logic [DATA_W-1:0] next_ier, next_fcr, next_lcr, next_mcr;
  logic [DATA_W-1:0] next_dll, next_dlm, next_dld, next_efr;
  logic [DATA_W-1:0] next_resume_char_one, next_resume_char_two, next_pause_char_one, next_pause_char_two;
  logic [DATA_W-1:0] next_scratch;
  logic [MODEM_W-1:0] next_modem_prev;
  logic [MODEM_W-1:0] next_modem_delta;

  // register writes; line and modem status writes are dropped
  always_comb begin
    next_ier = o_int_enable;
    next_fcr = o_fifo_control;
    next_lcr = o_line_control;
    next_mcr = o_modem_control;
    next_dll = o_divisor_low;
    next_dlm = o_divisor_high;
    next_dld = o_divisor_fraction;
    next_efr = o_enhanced_feature;
    next_resume_char_one = o_resume_char_one;
    next_resume_char_two = o_resume_char_two;
    next_pause_char_one = o_pause_char_one;
    next_pause_char_two = o_pause_char_two;
    next_scratch = scratch;
    if (wr_done) begin
      unique case (sel)
        SEL_IER: next_ier = wdata_lvl & enh_keep(IER_ENH_MASK, enh_on);
        // tx trigger bits need enhanced on
        SEL_ISR_FCR: next_fcr = wdata_lvl & enh_keep(FCR_ENH_MASK, enh_on);
        // line control, bit 7 steers decode
        SEL_LCR: next_lcr = wdata_lvl;
        // upper modem bits need enhanced on
        SEL_MCR: next_mcr = wdata_lvl & enh_keep(MCR_ENH_MASK, enh_on);
        SEL_SCR: next_scratch = wdata_lvl;
        SEL_DLL: next_dll = wdata_lvl;
        SEL_DLM: next_dlm = wdata_lvl;
        SEL_DLD: next_dld = wdata_lvl;
        SEL_EFR: begin
          next_efr = wdata_lvl;
          // turning enhanced off drops the gated bits
          if (!wdata_lvl[EFR_ENH_BIT]) begin
            next_ier = o_int_enable & ~IER_ENH_MASK;
            next_fcr = o_fifo_control & ~FCR_ENH_MASK;
            next_mcr = o_modem_control & ~MCR_ENH_MASK;
          end
        end
        SEL_RESUME_CHAR_ONE: next_resume_char_one = wdata_lvl;
        SEL_RESUME_CHAR_TWO: next_resume_char_two = wdata_lvl;
        SEL_PAUSE_CHAR_ONE: next_pause_char_one = wdata_lvl;
        SEL_PAUSE_CHAR_TWO: next_pause_char_two = wdata_lvl;
        // data port, status registers and holes store nothing here
        SEL_DATA, SEL_LSR, SEL_MSR, SEL_NONE: next_scratch = scratch;
      endcase
    end
    next_modem_prev = modem_b_lvl;
    // a change in the read cycle still sets its flag
    next_modem_delta = ((rd_start && sel == SEL_MSR) ? DELTA_NONE : modem_delta)
      | (modem_b_lvl ^ modem_prev);
  end

  // register file flops
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_int_enable <= RST_BYTE;
      o_fifo_control <= RST_BYTE;
      o_line_control <= RST_BYTE;
      o_modem_control <= RST_BYTE;
      o_divisor_low <= RST_BYTE;
      o_divisor_high <= RST_BYTE;
      o_divisor_fraction <= RST_BYTE;
      o_enhanced_feature <= RST_BYTE;
      o_resume_char_one <= RST_BYTE;
      o_resume_char_two <= RST_BYTE;
      o_pause_char_one <= RST_BYTE;
      o_pause_char_two <= RST_BYTE;
      scratch <= RST_BYTE;
      modem_prev <= MODEM_IDLE;
      modem_delta <= DELTA_NONE;
    end else begin
      o_int_enable <= next_ier;
      o_fifo_control <= next_fcr;
      o_line_control <= next_lcr;
      o_modem_control <= next_mcr;
      o_divisor_low <= next_dll;
      o_divisor_high <= next_dlm;
      o_divisor_fraction <= next_dld;
      o_enhanced_feature <= next_efr;
      o_resume_char_one <= next_resume_char_one;
      o_resume_char_two <= next_resume_char_two;
      o_pause_char_one <= next_pause_char_one;
      o_pause_char_two <= next_pause_char_two;
      scratch <= next_scratch;
      modem_prev <= next_modem_prev;
      modem_delta <= next_modem_delta;
    end
  end

endmodule // ucrm_channel_regs
`default_nettype wire

// [tb/ucrm_channel_regs_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// watches the host port and the overlay selection of one channel
module ucrm_channel_regs_asserts (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_rd_b,
  input wire logic [ucrm_pkg::DATA_W-1:0] i_rx_byte,
  input wire logic [ucrm_pkg::DATA_W-1:0] i_line_status,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_rx_read,
  input wire logic o_tx_load,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_tx_byte,
  input wire logic o_isr_read,
  input wire logic o_lsr_read,
  input wire logic o_fifo_write,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_int_enable,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_fifo_control,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_line_control,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_divisor_low,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_divisor_fraction,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_enhanced_feature,
  input wire logic [ucrm_pkg::DATA_W-1:0] o_resume_char_one
);
  import ucrm_pkg::*;
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  property p_rx_read;
    o_rx_read |-> o_data_oe && !o_line_control[LCR_DIV_BIT] && o_data == $past(i_rx_byte);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx read mismatch");
  property p_tx_load;
    $changed(o_tx_byte) |-> o_tx_load && !o_line_control[LCR_DIV_BIT];
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx byte moved");
  property p_ier_gate;
    $changed(o_int_enable) && !o_enhanced_feature[EFR_ENH_BIT]
      |-> (o_int_enable & IER_ENH_MASK) == RST_BYTE;
  endproperty
  a_ier_gate: assert property (p_ier_gate) else $error("gated enable bits set");
  property p_isr;
    o_isr_read |-> o_data[7:6] == {2{o_fifo_control[FCR_EN_BIT]}}
      && (o_enhanced_feature[EFR_ENH_BIT] || o_data[5:4] == 2'h0);
  endproperty
  a_isr: assert property (p_isr) else $error("status flags wrong");
  property p_fifo;
    o_fifo_write |-> !o_line_control[LCR_DIV_BIT]
      && (o_enhanced_feature[EFR_ENH_BIT] || (o_fifo_control & FCR_ENH_MASK) == RST_BYTE);
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo control write wrong");
  property p_lsr;
    o_lsr_read |-> o_data == $past(i_line_status);
  endproperty
  a_lsr: assert property (p_lsr) else $error("line status read wrong");
  property p_div;
    $changed(o_divisor_low) |-> o_line_control[LCR_DIV_BIT] && o_line_control != ENH_KEY;
  endproperty
  a_div: assert property (p_div) else $error("divisor written outside its mode");
  property p_dld;
    $changed(o_divisor_fraction) |-> o_enhanced_feature[EFR_ENH_BIT]
      && o_line_control[LCR_DIV_BIT] && o_line_control != ENH_KEY;
  endproperty
  a_dld: assert property (p_dld) else $error("fraction written while closed");
  property p_xon;
    $changed(o_resume_char_one) |-> o_line_control == ENH_KEY;
  endproperty
  a_xon: assert property (p_xon) else $error("flow char written without key");
  property p_oe_rise;
    $rose(o_data_oe) |-> !$past(i_cs_b, 3) && !$past(i_rd_b, 3) && !i_rd_b;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive without read strobe");
  property p_oe_idle;
    i_rd_b [*8] |-> !o_data_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("bus driven while idle");
endmodule // ucrm_channel_regs_asserts

bind ucrm_channel_regs ucrm_channel_regs_asserts u_chk (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_rd_b(i_rd_b), .i_rx_byte(i_rx_byte),
  .i_line_status(i_line_status), .o_data(o_data), .o_data_oe(o_data_oe),
  .o_rx_read(o_rx_read), .o_tx_load(o_tx_load), .o_tx_byte(o_tx_byte),
  .o_isr_read(o_isr_read), .o_lsr_read(o_lsr_read), .o_fifo_write(o_fifo_write),
  .o_int_enable(o_int_enable), .o_fifo_control(o_fifo_control),
  .o_line_control(o_line_control), .o_divisor_low(o_divisor_low),
  .o_divisor_fraction(o_divisor_fraction), .o_enhanced_feature(o_enhanced_feature),
  .o_resume_char_one(o_resume_char_one));
`default_nettype wire

// [tb/ucrm_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// host processor on the parallel pins, one access at a time
module ucrm_host_model (
  input wire logic i_core_clk,
  input wire logic [ucrm_pkg::DATA_W-1:0] i_data,
  input wire logic i_data_oe,
  output logic o_cs_b,
  output logic o_rd_b,
  output logic o_wr_b,
  output logic [ucrm_pkg::ADDR_W-1:0] o_addr,
  output logic [ucrm_pkg::DATA_W-1:0] o_data
);
  import ucrm_pkg::*;
  // pins idle from time zero
  initial begin
    o_cs_b = 1'b1;
    o_rd_b = 1'b1;
    o_wr_b = 1'b1;
    o_addr = ADDR_DATA;
    o_data = RST_BYTE;
  end
  // let n rising edges pass
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // write: strobe low six cycles, then hold address and data past the filter
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_data <= d;
    @(posedge i_core_clk);
    o_cs_b <= 1'b0;
    o_wr_b <= 1'b0;
    idle(6);
    o_cs_b <= 1'b1;
    o_wr_b <= 1'b1;
    idle(6);
    // released bus shows the inverse, never a stale byte
    o_data <= ~d;
  endtask
  // read: hold the strobe until the drive enable is sampled high
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    @(posedge i_core_clk);
    o_addr <= a;
    @(posedge i_core_clk);
    o_cs_b <= 1'b0;
    o_rd_b <= 1'b0;
    n = 0;
    d = 'x;
    // bounded wait, a missing answer leaves unknown data
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_data_oe !== 1'b1 && n < 20);
    if (i_data_oe === 1'b1) begin
      d = i_data;
    end
    o_cs_b <= 1'b1;
    o_rd_b <= 1'b1;
    idle(7);
  endtask
endmodule // ucrm_host_model
`default_nettype wire

// [tb/ucrm_channel_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
// register map bench: host accesses with expected read values
module ucrm_channel_regs_tb;
  import ucrm_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  // modem pins and status from a stand-in channel core; the core status is held steady, the modem pins are changed by the test
  logic [3:0] modem_b = 4'hF;
  logic [DATA_W-1:0] rx_byte = 8'h3C;
  logic [DATA_W-1:0] line_status = 8'h61;
  wire logic cs_b, rd_b, wr_b, data_oe;
  wire logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] wdata, rdata, tx_byte, fifo_ctl, line_control, div_low, interrupt_enable, frac;
  int err_count = 0;
  int comparisons = 0;
  int i;

  // 25 MHz clock
  always #20 i_core_clk = ~i_core_clk;

  ucrm_host_model host (.i_core_clk(i_core_clk), .i_data(rdata), .i_data_oe(data_oe),
    .o_cs_b(cs_b), .o_rd_b(rd_b), .o_wr_b(wr_b), .o_addr(addr), .o_data(wdata));

  ucrm_channel_regs dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b),
    .i_rd_b(rd_b), .i_wr_b(wr_b), .i_addr(addr), .i_data(wdata), .o_data(rdata),
    .o_data_oe(data_oe), .i_cts_b(modem_b[0]), .i_dsr_b(modem_b[1]),
    .i_ri_b(modem_b[2]), .i_cd_b(modem_b[3]), .i_rx_byte(rx_byte),
    .i_line_status(line_status), .i_int_source(4'h6), .i_xoff_int(1'b1),
    .i_rtscts_int(1'b1), .o_rx_read(), .o_tx_load(), .o_tx_byte(tx_byte),
    .o_isr_read(), .o_lsr_read(), .o_fifo_write(), .o_int_enable(interrupt_enable),
    .o_fifo_control(fifo_ctl), .o_line_control(line_control), .o_modem_control(),
    .o_divisor_low(div_low), .o_divisor_high(), .o_divisor_fraction(frac),
    .o_enhanced_feature(), .o_resume_char_one(), .o_resume_char_two(),
    .o_pause_char_one(), .o_pause_char_two());

  // compare and count, case equality so unknowns fail
  task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // read one address and compare
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    host.rd(a, d);
    cmp(d, e);
  endtask
  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask
  // the single place the run ends
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge i_core_clk);
    err_count++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    rchk(ADDR_IER, RST_BYTE);
    rchk(ADDR_LCR, RST_BYTE);
    rchk(ADDR_MCR, RST_BYTE);
    host.wr(ADDR_SCR, 8'hA5);
    rchk(ADDR_SCR, 8'hA5);
    host.wr(ADDR_LCR, 8'h1B);
    cmp(line_control, 8'h1B);
    rchk(ADDR_LCR, 8'h1B);
    test_end("plain");
    // gated bits dropped while enhanced is off
    host.wr(ADDR_IER, 8'hFF);
    rchk(ADDR_IER, 8'h0F);
    host.wr(ADDR_MCR, 8'hFB);
    rchk(ADDR_MCR, 8'h1B);
    rchk(ADDR_DATA, 8'h3C);
    host.wr(ADDR_DATA, 8'h5A);
    cmp(tx_byte, 8'h5A);
    rchk(ADDR_ISR, 8'h06);
    host.wr(ADDR_ISR, 8'h31);
    cmp(fifo_ctl, 8'h01);
    rchk(ADDR_ISR, 8'hC6);
    rchk(ADDR_LSR, 8'h61);
    test_end("standard");
    // modem deltas set by pin changes, cleared by a read
    rchk(ADDR_MSR, 8'h00);
    @(posedge i_core_clk);
    modem_b <= 4'hE;
    repeat (10) @(posedge i_core_clk);
    rchk(ADDR_MSR, 8'h11);
    rchk(ADDR_MSR, 8'h10);
    @(posedge i_core_clk);
    modem_b <= 4'h0;
    repeat (10) @(posedge i_core_clk);
    rchk(ADDR_MSR, 8'hFE);
    rchk(ADDR_MSR, 8'hF0);
    test_end("modem");
    // divisor set overlays the first two addresses
    host.wr(ADDR_LCR, 8'h80);
    host.wr(ADDR_DATA, 8'h12);
    host.wr(ADDR_IER, 8'h34);
    rchk(ADDR_DATA, 8'h12);
    rchk(ADDR_IER, 8'h34);
    cmp(div_low, 8'h12);
    cmp(interrupt_enable, 8'h0F);
    cmp(tx_byte, 8'h5A);
    host.wr(ADDR_ISR, 8'h3F);
    rchk(ADDR_ISR, 8'h00);
    test_end("divisor");
    // key value opens the enhanced set
    host.wr(ADDR_LCR, ENH_KEY);
    host.wr(ADDR_ISR, 8'h10);
    rchk(ADDR_ISR, 8'h10);
    for (i = 4; i < 8; i++) begin
      host.wr(i[ADDR_W-1:0], 8'h40 + i[DATA_W-1:0]);
    end
    for (i = 4; i < 8; i++) begin
      rchk(i[ADDR_W-1:0], 8'h40 + i[DATA_W-1:0]);
    end
    host.wr(ADDR_LCR, 8'h80);
    host.wr(ADDR_ISR, 8'h3F);
    rchk(ADDR_ISR, 8'h3F);
    cmp(frac, 8'h3F);
    host.wr(ADDR_LCR, RST_BYTE);
    host.wr(ADDR_IER, 8'hFF);
    rchk(ADDR_IER, 8'hFF);
    host.wr(ADDR_ISR, 8'h31);
    rchk(ADDR_ISR, 8'hF6);
    test_end("enhanced");
    summarize();
  end
endmodule // ucrm_channel_regs_tb
`default_nettype wire
